// file: qsp_cdc_if.sv
// Crossing bundle between the system-clock register side and the
// link-clock side of the slice. Every signal is a toggle: an event is
// a change of level, so neither side needs to know the other's rate.
`timescale 1ns/1ps
`default_nettype none
interface qsp_cdc_if;
  logic start_tgl;
  logic stop_tgl;
  logic end_tgl;

  modport sys (
    output start_tgl,
    output stop_tgl,
    input  end_tgl
  );

  modport link (
    input  start_tgl,
    input  stop_tgl,
    output end_tgl
  );
endinterface
`default_nettype wire

// file: qsp_engine_model.sv
// Behavioural transfer engine facing the slice on the link clock.
// Assumes start and stop arrive as one-cycle pulses on clk_link.
`timescale 1ns/1ps
`default_nettype none
module qsp_engine_model #(
  parameter int NBYTES   = 6,
  parameter int BYTE_CYC = 4
) (
  // Link clock and reset
  input  wire logic       clk_link,
  input  wire logic       rst,
  // Engine handshake
  input  wire logic       eng_start,
  input  wire logic       eng_stop,
  output logic            eng_byte_done,
  output logic            eng_xfer_done,
  // Activity and progress
  output logic            busy,
  output logic [7:0]      n_bytes
);
  int cyc_q;

  // A stop only ever lands right after a byte boundary, so halting here
  // leaves the byte count at whole bytes.
  always_ff @(posedge clk_link or posedge rst) begin
    if (rst) begin
      busy <= 1'b0;
      cyc_q <= 0;
      n_bytes <= 8'h00;
      eng_byte_done <= 1'b0;
      eng_xfer_done <= 1'b0;
    end else begin
      eng_byte_done <= 1'b0;
      eng_xfer_done <= 1'b0;
      if (eng_start && !busy) begin
        busy <= 1'b1;
        cyc_q <= 0;
        n_bytes <= 8'h00;
      end else if (eng_stop) begin
        busy <= 1'b0;
      end else if (busy) begin
        cyc_q <= (cyc_q == BYTE_CYC - 1) ? 0 : cyc_q + 1;
        if (cyc_q == BYTE_CYC - 1) begin
          n_bytes <= n_bytes + 8'h01;
          eng_byte_done <= 1'b1;
          eng_xfer_done <= (n_bytes == 8'(NBYTES - 1));
          busy <= (n_bytes != 8'(NBYTES - 1));
        end
      end
    end
  end
endmodule
`default_nettype wire

// file: qsp_link_ctl.sv
// Link-clock side of the slice: turns start and stop events into
// engine pulses, holding a stop until the engine reports a byte boundary.
// Assumes the transfer engine runs on clk_link and drives its done
// strobes as one-cycle pulses on that clock.
`timescale 1ns/1ps
`default_nettype none
module qsp_link_ctl (
  // Link clock and reset
  input  wire logic clk_link,
  input  wire logic rst,
  // Crossing bundle
  qsp_cdc_if.link   cdc,
  // Transfer engine
  input  wire logic eng_byte_done,
  input  wire logic eng_xfer_done,
  output logic      eng_start,
  output logic      eng_stop
);

  typedef enum logic [1:0] {QSP_L_IDLE, QSP_L_RUN, QSP_L_STOPPING} qsp_lstate_t;

  qsp_lstate_t state_q;
  logic [2:0]  start_sync_q;
  logic [2:0]  stop_sync_q;
  logic        start_ev;
  logic        stop_ev;
  logic        end_tgl_q;
  logic        eng_start_q;
  logic        eng_stop_q;

  // ----------------------------------------------------------------
  // Event crossing
  // ----------------------------------------------------------------
  always_ff @(posedge clk_link or posedge rst) begin
    if (rst) begin
      start_sync_q <= 3'h0;
      stop_sync_q  <= 3'h0;
    end else begin
      start_sync_q <= {start_sync_q[1:0], cdc.start_tgl};
      stop_sync_q  <= {stop_sync_q[1:0], cdc.stop_tgl};
    end
  end

  assign start_ev = start_sync_q[2] ^ start_sync_q[1];
  assign stop_ev  = stop_sync_q[2] ^ stop_sync_q[1];

  // ----------------------------------------------------------------
  // Transfer sequencing
  // ----------------------------------------------------------------
  always_ff @(posedge clk_link or posedge rst) begin
    if (rst) begin
      state_q     <= QSP_L_IDLE;
      end_tgl_q   <= 1'b0;
      eng_start_q <= 1'b0;
      eng_stop_q  <= 1'b0;
    end else begin
      eng_start_q <= 1'b0;
      eng_stop_q  <= 1'b0;
      unique case (state_q)
        QSP_L_IDLE: begin
          if (start_ev) begin
            eng_start_q <= 1'b1;
            state_q     <= QSP_L_RUN;
          end
        end
        QSP_L_RUN: begin
          if (eng_xfer_done) begin
            end_tgl_q <= ~end_tgl_q;
            state_q   <= QSP_L_IDLE;
          end else if (stop_ev) begin
            state_q <= QSP_L_STOPPING;
          end
        end
        QSP_L_STOPPING: begin
          // The engine is only halted between bytes, never mid-byte.
          if (eng_byte_done || eng_xfer_done) begin
            eng_stop_q <= ~eng_xfer_done;
            end_tgl_q  <= ~end_tgl_q;
            state_q    <= QSP_L_IDLE;
          end
        end
      endcase
    end
  end

  assign cdc.end_tgl = end_tgl_q;
  assign eng_start   = eng_start_q;
  assign eng_stop    = eng_stop_q;

endmodule
`default_nettype wire

// file: qsp_pkg.sv
// Package for the quad SPI master command and pin-control slice.
// Assumes a byte-addressed register port with one 32-bit word per register.
package qsp_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] QSP_OFF_TRANSFER_COMMAND  = 8'h08;
  localparam logic [7:0] QSP_OFF_PIN_DRIVE_CONTROL = 8'h0c;
  localparam logic [7:0] QSP_OFF_STATUS            = 8'h10;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int QSP_CMD_START_BIT = 0;
  localparam int QSP_CMD_STOP_BIT  = 1;
  localparam int QSP_CMD_FLUSH_BIT = 2;

  localparam int QSP_PDC_WP_VALUE_BIT     = 0;
  localparam int QSP_PDC_WP_ENABLE_BIT    = 1;
  localparam int QSP_PDC_HOLD_VALUE_BIT   = 2;
  localparam int QSP_PDC_HOLD_ENABLE_BIT  = 3;
  localparam int QSP_PDC_RX_PULLDOWN_BIT  = 4;
  localparam int QSP_PDC_RX_PULLUP_BIT    = 5;
  localparam int QSP_PDC_TX_PULLDOWN_BIT  = 6;
  localparam int QSP_PDC_TX_PULLUP_BIT    = 7;
  localparam int QSP_PDC_WIDTH            = 8;

  localparam int QSP_STS_ACTIVE_BIT = 16;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [QSP_PDC_WIDTH-1:0] QSP_PDC_RESET = 8'h00;
  localparam logic [31:0]              QSP_RD_ZERO   = 32'h0000_0000;

endpackage

// file: qsp_top.sv
// Command and pin-control slice of a quad SPI master: transfer command
// register, pin drive control register and the transfer-active status.
// Assumes a register master on clk_sys that never issues both strobes at
// once, and a transfer engine and FIFOs outside this slice. The engine
// side runs on clk_link; pads and chip select arrive asynchronously.
//
// Implementation choice: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module qsp_top
  import qsp_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  // System clock and reset
  input  wire logic              clk_sys,
  input  wire logic              rst,

  // Register port
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [31:0]       reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [31:0]       reg_rdata,

  // Link clock and transfer engine
  input  wire logic              clk_link,
  input  wire logic              eng_byte_done,
  input  wire logic              eng_xfer_done,
  output logic                   eng_start,
  output logic                   eng_stop,

  // FIFO control
  output logic                   fifo_flush,

  // Pad status inputs, asynchronous
  input  wire logic              tx_driven,
  input  wire logic              spi_cs_n,

  // Pad pull controls
  output logic                   tx_pullup_en,
  output logic                   tx_pulldown_en,
  output logic                   rx_deselect_pullup_en,
  output logic                   rx_deselect_pulldown_en,

  // Flash side-band pins
  output logic                   hold_out,
  output logic                   hold_oe,
  output logic                   wp_out,
  output logic                   wp_oe
);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  // The decoder compares against 8-bit offsets, so a narrower port
  // would alias the status word onto the command registers.
  if (ADDR_W < 8) begin : g_addr_chk
    $error("ADDR_W must be at least 8");
  end

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [QSP_PDC_WIDTH-1:0] pdc_q;
  logic                     start_tgl_q;
  logic                     stop_tgl_q;
  logic                     flush_q;
  logic                     active_q;
  logic [31:0]              rdata_q;
  logic [2:0]               end_sync_q;
  logic                     end_ev;
  logic [1:0]               txd_sync_q;
  logic [1:0]               cs_sync_q;
  logic                     tx_pu_q;
  logic                     tx_pd_q;
  logic                     rx_pu_q;
  logic                     rx_pd_q;
  logic                     hold_out_q;
  logic                     hold_oe_q;
  logic                     wp_out_q;
  logic                     wp_oe_q;
  logic [7:0]               addr_lo;
  logic                     addr_hi_zero;
  logic                     sel_cmd;
  logic                     sel_pdc;
  logic                     sel_sts;
  logic                     wr_cmd;
  logic                     wr_pdc;
  logic                     cmd_start;
  logic                     cmd_stop;
  logic                     cmd_flush;

  qsp_cdc_if cdc ();

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  assign addr_lo      = reg_addr[7:0];
  assign addr_hi_zero = (reg_addr >> 8) == '0;
  assign sel_cmd      = addr_hi_zero && (addr_lo == QSP_OFF_TRANSFER_COMMAND);
  assign sel_pdc      = addr_hi_zero && (addr_lo == QSP_OFF_PIN_DRIVE_CONTROL);
  assign sel_sts      = addr_hi_zero && (addr_lo == QSP_OFF_STATUS);
  assign wr_cmd       = reg_wr && sel_cmd;
  assign wr_pdc       = reg_wr && sel_pdc;

  // A write with both start and stop set is outside the contract; stop
  // is given priority so the engine is never started and stopped at once.
  assign cmd_stop  = wr_cmd && reg_wdata[QSP_CMD_STOP_BIT];
  assign cmd_start = wr_cmd && reg_wdata[QSP_CMD_START_BIT] && !cmd_stop;
  assign cmd_flush = wr_cmd && reg_wdata[QSP_CMD_FLUSH_BIT];

  // ----------------------------------------------------------------
  // Pin drive control register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pdc_q <= QSP_PDC_RESET;
    end else if (wr_pdc) begin
      pdc_q <= reg_wdata[QSP_PDC_WIDTH-1:0];
    end
  end

  // ----------------------------------------------------------------
  // Command pulses
  // ----------------------------------------------------------------
  // Command bits have no storage: a write of one raises an event for
  // exactly one cycle, and a write of zero leaves every event alone.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      start_tgl_q <= 1'b0;
      stop_tgl_q  <= 1'b0;
    end else begin
      if (cmd_start) begin
        start_tgl_q <= ~start_tgl_q;
      end
      if (cmd_stop) begin
        stop_tgl_q <= ~stop_tgl_q;
      end
    end
  end

  // The FIFOs sit on the system clock, so the flush needs no crossing.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      flush_q <= 1'b0;
    end else begin
      flush_q <= cmd_flush;
    end
  end

  assign cdc.start_tgl = start_tgl_q;
  assign cdc.stop_tgl  = stop_tgl_q;

  // ----------------------------------------------------------------
  // Link-side sequencer
  // ----------------------------------------------------------------
  qsp_link_ctl u_link (
    .clk_link      (clk_link),
    .rst           (rst),
    .cdc           (cdc.link),
    .eng_byte_done (eng_byte_done),
    .eng_xfer_done (eng_xfer_done),
    .eng_start     (eng_start),
    .eng_stop      (eng_stop)
  );

  // ----------------------------------------------------------------
  // Transfer-active status
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      end_sync_q <= 3'h0;
    end else begin
      end_sync_q <= {end_sync_q[1:0], cdc.end_tgl};
    end
  end

  assign end_ev = end_sync_q[2] ^ end_sync_q[1];

  // The flag is raised on the command write itself so firmware that
  // polls straight after a start never sees a stale zero. A start in the
  // same cycle as the end event wins over it, and the flag stays set.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      active_q <= 1'b0;
    end else if (cmd_start) begin
      active_q <= 1'b1;
    end else if (end_ev) begin
      active_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Pad status synchronisers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      txd_sync_q <= 2'h0;
      cs_sync_q  <= 2'h3;
    end else begin
      txd_sync_q <= {txd_sync_q[0], tx_driven};
      cs_sync_q  <= {cs_sync_q[0], spi_cs_n};
    end
  end

  // ----------------------------------------------------------------
  // Pad pull controls
  // ----------------------------------------------------------------
  // Pulls follow the pad state three cycles late; the pad driver itself
  // overrides a weak pull, so the short overlap is harmless.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      tx_pu_q <= 1'b0;
      tx_pd_q <= 1'b0;
      rx_pu_q <= 1'b0;
      rx_pd_q <= 1'b0;
    end else begin
      tx_pu_q <= pdc_q[QSP_PDC_TX_PULLUP_BIT] && !txd_sync_q[1];
      tx_pd_q <= pdc_q[QSP_PDC_TX_PULLDOWN_BIT] && !txd_sync_q[1];
      rx_pu_q <= pdc_q[QSP_PDC_RX_PULLUP_BIT] && cs_sync_q[1];
      rx_pd_q <= pdc_q[QSP_PDC_RX_PULLDOWN_BIT] && cs_sync_q[1];
    end
  end

  // ----------------------------------------------------------------
  // HOLD and write-protect drivers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      hold_oe_q  <= 1'b0;
      hold_out_q <= 1'b0;
      wp_oe_q    <= 1'b0;
      wp_out_q   <= 1'b0;
    end else begin
      hold_oe_q  <= pdc_q[QSP_PDC_HOLD_ENABLE_BIT];
      hold_out_q <= pdc_q[QSP_PDC_HOLD_VALUE_BIT];
      wp_oe_q    <= pdc_q[QSP_PDC_WP_ENABLE_BIT];
      wp_out_q   <= pdc_q[QSP_PDC_WP_VALUE_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  // The command register is write-only and reads as zero, as does any
  // address outside the three words of this slice.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rdata_q <= QSP_RD_ZERO;
    end else if (reg_rd) begin
      rdata_q <= QSP_RD_ZERO;
      if (sel_pdc) begin
        rdata_q[QSP_PDC_WIDTH-1:0] <= pdc_q;
      end else if (sel_sts) begin
        rdata_q[QSP_STS_ACTIVE_BIT] <= active_q;
      end
    end else begin
      rdata_q <= QSP_RD_ZERO;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign reg_rdata               = rdata_q;
  assign fifo_flush              = flush_q;
  assign tx_pullup_en            = tx_pu_q;
  assign tx_pulldown_en          = tx_pd_q;
  assign rx_deselect_pullup_en   = rx_pu_q;
  assign rx_deselect_pulldown_en = rx_pd_q;
  assign hold_out                = hold_out_q;
  assign hold_oe                 = hold_oe_q;
  assign wp_out                  = wp_out_q;
  assign wp_oe                   = wp_oe_q;

endmodule
`default_nettype wire

// file: qsp_top_properties.sv
// Checker for the command and pin-control slice, bound to qsp_top.
// Assumes the register timing and pad latencies of the top module's ports.
`timescale 1ns/1ps
`default_nettype none
module qsp_top_properties
  import qsp_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  // Clocks and reset
  input wire logic              clk_sys,
  input wire logic              clk_link,
  input wire logic              rst,
  // Register port
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [31:0]       reg_wdata,
  input wire logic              reg_wr,
  input wire logic              reg_rd,
  input wire logic [31:0]       reg_rdata,
  // Engine, FIFO and pads
  input wire logic              eng_byte_done,
  input wire logic              eng_stop,
  input wire logic              fifo_flush,
  input wire logic              tx_driven,
  input wire logic              spi_cs_n,
  input wire logic              tx_pullup_en,
  input wire logic              tx_pulldown_en,
  input wire logic              rx_deselect_pullup_en,
  input wire logic              rx_deselect_pulldown_en,
  input wire logic              hold_out,
  input wire logic              hold_oe,
  input wire logic              wp_out,
  input wire logic              wp_oe
);
  // ----------------------------------------------------------------
  // Register accesses
  // ----------------------------------------------------------------
  sequence s_flush_wr;
    reg_wr && reg_addr == QSP_OFF_TRANSFER_COMMAND && reg_wdata[QSP_CMD_FLUSH_BIT];
  endsequence
  sequence s_pdc_wr;
    reg_wr && reg_addr == QSP_OFF_PIN_DRIVE_CONTROL;
  endsequence
  sequence s_pulse_gone(x);
    x ##1 !x;
  endsequence

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  property p_flush;
    @(posedge clk_sys) disable iff (rst) s_flush_wr |=> fifo_flush;
  endproperty
  a_flush: assert property (p_flush) else $error("flush write gave no flush pulse");
  property p_flush_src;
    @(posedge clk_sys) disable iff (rst)
      fifo_flush |-> $past(reg_wr && reg_addr == QSP_OFF_TRANSFER_COMMAND
                           && reg_wdata[QSP_CMD_FLUSH_BIT]) ##0 s_pulse_gone(fifo_flush);
  endproperty
  a_flush_src: assert property (p_flush_src) else $error("flush pulse without cause");
  property p_hold;
    @(posedge clk_sys) disable iff (rst) s_pdc_wr |-> ##2 (hold_oe == $past(reg_wdata[3], 2)
      && (!hold_oe || hold_out == $past(reg_wdata[2], 2)));
  endproperty
  a_hold: assert property (p_hold) else $error("hold pin differs from control");
  property p_wp;
    @(posedge clk_sys) disable iff (rst) s_pdc_wr |-> ##2 (wp_oe == $past(reg_wdata[1], 2)
      && (!wp_oe || wp_out == $past(reg_wdata[0], 2)));
  endproperty
  a_wp: assert property (p_wp) else $error("write-protect pin differs from control");
  property p_tx_pull;
    @(posedge clk_sys) disable iff (rst)
      $past(tx_driven, 2) && $past(tx_driven, 3) && $past(tx_driven, 4)
      |-> !tx_pullup_en && !tx_pulldown_en;
  endproperty
  a_tx_pull: assert property (p_tx_pull) else $error("transmit pull while driven");
  property p_rx_pull;
    @(posedge clk_sys) disable iff (rst)
      !$past(spi_cs_n, 2) && !$past(spi_cs_n, 3) && !$past(spi_cs_n, 4)
      |-> !rx_deselect_pullup_en && !rx_deselect_pulldown_en;
  endproperty
  a_rx_pull: assert property (p_rx_pull) else $error("receive pull while selected");
  property p_stop;
    @(posedge clk_link) disable iff (rst) eng_stop |-> $past(eng_byte_done) ##1 !eng_stop;
  endproperty
  a_stop: assert property (p_stop) else $error("stop off a byte boundary");
  property p_cmd_rd;
    @(posedge clk_sys) disable iff (rst)
      reg_rd && reg_addr == QSP_OFF_TRANSFER_COMMAND |=> reg_rdata == QSP_RD_ZERO;
  endproperty
  a_cmd_rd: assert property (p_cmd_rd) else $error("command register read nonzero");
  property p_pdc_rd;
    @(posedge clk_sys) disable iff (rst)
      reg_rd && reg_addr == QSP_OFF_PIN_DRIVE_CONTROL |=> reg_rdata[31:8] == 24'h00_0000;
  endproperty
  a_pdc_rd: assert property (p_pdc_rd) else $error("reserved control bits read nonzero");
  property p_reset;
    @(posedge clk_sys) disable iff (rst) $fell(rst) |-> !(hold_oe || wp_oe || fifo_flush
      || tx_pullup_en || tx_pulldown_en || rx_deselect_pullup_en || rx_deselect_pulldown_en);
  endproperty
  a_reset: assert property (p_reset) else $error("output active right after reset");
endmodule

bind qsp_top qsp_top_properties #(.ADDR_W(ADDR_W)) u_props (
  .clk_sys(clk_sys), .clk_link(clk_link), .rst(rst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .eng_byte_done(eng_byte_done), .eng_stop(eng_stop), .fifo_flush(fifo_flush),
  .tx_driven(tx_driven), .spi_cs_n(spi_cs_n), .tx_pullup_en(tx_pullup_en),
  .tx_pulldown_en(tx_pulldown_en), .rx_deselect_pullup_en(rx_deselect_pullup_en),
  .rx_deselect_pulldown_en(rx_deselect_pulldown_en), .hold_out(hold_out),
  .hold_oe(hold_oe), .wp_out(wp_out), .wp_oe(wp_oe)
);
`default_nettype wire

// file: test_qsp_top.sv
// Testbench for the command and pin-control slice with an engine model.
// Assumes the register port answers reads one cycle after the strobe.
`timescale 1ns/1ps
`default_nettype none
module test_qsp_top;
  import qsp_pkg::*;
  logic        clk_sys, clk_link, rst, reg_wr, reg_rd, pad_drv, pad_cs_n;
  logic [7:0]  reg_addr, n_bytes;
  logic [31:0] reg_wdata, reg_rdata, d;
  logic        eng_byte_done, eng_xfer_done, eng_start, eng_stop, fifo_flush, busy;
  logic        tx_pu, tx_pd, rx_pu, rx_pd, hold_out, hold_oe, wp_out, wp_oe;
  logic [7:0]  pat [4] = '{8'ha5, 8'h5a, 8'h00, 8'hff};
  int          n_errors = 0, n_tests = 0, n_start = 0, n_stop = 0;

  qsp_top #(.ADDR_W(8)) uut (
    .clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .clk_link(clk_link),
    .eng_byte_done(eng_byte_done), .eng_xfer_done(eng_xfer_done), .eng_start(eng_start),
    .eng_stop(eng_stop), .fifo_flush(fifo_flush), .tx_driven(busy | pad_drv),
    .spi_cs_n(!busy & pad_cs_n), .tx_pullup_en(tx_pu), .tx_pulldown_en(tx_pd),
    .rx_deselect_pullup_en(rx_pu), .rx_deselect_pulldown_en(rx_pd),
    .hold_out(hold_out), .hold_oe(hold_oe), .wp_out(wp_out), .wp_oe(wp_oe));
  qsp_engine_model #(.NBYTES(6), .BYTE_CYC(4)) u_eng (
    .clk_link(clk_link), .rst(rst), .eng_start(eng_start), .eng_stop(eng_stop),
    .eng_byte_done(eng_byte_done), .eng_xfer_done(eng_xfer_done), .busy(busy),
    .n_bytes(n_bytes));

  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  initial begin
    clk_link = 1'b0;
    #7;
    forever #32 clk_link = ~clk_link;
  end
  always @(posedge clk_link) begin
    n_start += (eng_start === 1'b1);
    n_stop += (eng_stop === 1'b1);
  end

  // ----------------------------------------------------------------
  // Access and compare tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= wd;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    rd(a);
    chk(d, exp);
  endtask
  // Outputs in the control register's bit order; a level is masked while undriven.
  function automatic logic [31:0] pins();
    return {24'h0, tx_pu, tx_pd, rx_pu, rx_pd, hold_oe, hold_oe & hold_out, wp_oe, wp_oe & wp_out};
  endfunction
  task automatic wait_idle;
    for (int i = 0; i < 300; i++) begin
      rd(QSP_OFF_STATUS);
      if (d === 32'h0) break;
    end
    chk(d, 32'h0);
  endtask
  task automatic results;
    if (n_errors == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk_sys);
    n_errors++;
    results();
  end

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    {rst, reg_wr, reg_rd, reg_addr, reg_wdata, pad_drv, pad_cs_n} = {3'b100, 8'h00, 32'h0, 2'b01};
    repeat (10) @(posedge clk_sys);
    rst <= 1'b0;
    rdchk(QSP_OFF_PIN_DRIVE_CONTROL, 32'h0);
    chk(pins(), 32'h0);
    foreach (pat[i]) begin
      wr(QSP_OFF_PIN_DRIVE_CONTROL, {24'hff_ffff, pat[i]});
      rdchk(QSP_OFF_PIN_DRIVE_CONTROL, {24'h0, pat[i]});
      chk(pins(), {24'h0, pat[i][7:3], pat[i][3] & pat[i][2], pat[i][1], pat[i][1] & pat[i][0]});
    end
    for (int k = 0; k < 4; k++) begin
      @(posedge clk_sys);
      pad_drv <= k[0];
      pad_cs_n <= k[1];
      repeat (4) @(posedge clk_sys);
      #1 chk(pins(), {24'h0, {2{!k[0]}}, {2{k[1]}}, 4'hf});
    end
    @(posedge clk_sys);
    pad_drv <= 1'b0;
    wr(8'h00, 32'hffff_ffff);
    rdchk(8'h00, 32'h0);
    rdchk(8'h14, 32'h0);
    wr(QSP_OFF_TRANSFER_COMMAND, 32'h0000_0004);
    chk({31'h0, fifo_flush}, 32'h1);
    @(posedge clk_sys);
    #1 chk({31'h0, fifo_flush}, 32'h0);
    wr(QSP_OFF_TRANSFER_COMMAND, 32'hffff_fff8);
    chk({31'h0, fifo_flush}, 32'h0);
    wr(QSP_OFF_TRANSFER_COMMAND, 32'h0000_0002);
    wr(QSP_OFF_TRANSFER_COMMAND, 32'h0000_0001);
    rdchk(QSP_OFF_STATUS, 32'h0001_0000);
    rdchk(QSP_OFF_TRANSFER_COMMAND, 32'h0);
    wait_idle();
    chk(32'(n_start), 32'h1);
    chk({24'h0, n_bytes}, 32'h6);
    chk(32'(n_stop), 32'h0);
    wr(QSP_OFF_TRANSFER_COMMAND, 32'h0000_0001);
    repeat (30) @(posedge clk_sys);
    wr(QSP_OFF_TRANSFER_COMMAND, 32'h0000_0002);
    wait_idle();
    chk(32'(n_stop), 32'h1);
    chk({31'h0, n_bytes inside {[8'h01:8'h05]}}, 32'h1);
    chk(32'(n_start), 32'h2);
    results();
  end
endmodule
`default_nettype wire
